//--- core/wtc_consts.svh
/*
  Constants of the write-through cache controller: sizes, address field
  positions and reset values. Assumes it is included by bare name after
  any header comment, from the package and the design modules.
*/
`ifndef WTC_CONSTS_SVH
`define WTC_CONSTS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define WTC_ADDR_W    16
`define WTC_DATA_W    32
`define WTC_WAYS      4
`define WTC_WAY_W     2
`define WTC_SETS      16
`define WTC_SET_W     4
`define WTC_OFF_W     2
`define WTC_TAG_W     10
`define WTC_WORDS     256
`define WTC_IDX_W     8

// ----------------------------------------------------------------------
// Address fields (word address) and fixed values
// ----------------------------------------------------------------------
`define WTC_OFF_LSB   0
`define WTC_SET_LSB   2
`define WTC_TAG_LSB   6
`define WTC_LINE_LAST 2'h3
`define WTC_AGE_OLD   2'h3
`define WTC_AGE_RST   8'he4

`endif

//--- core/wtc_pkg.sv
/*
  Types shared by the cache controller and its tag directory.
  Assumes wtc_consts.svh is on the include path.
*/
`default_nettype none
`include "wtc_consts.svh"

package wtc_pkg;
  typedef enum logic {st_idle, st_refill}          wtc_state_type;
  typedef logic [`WTC_ADDR_W-1:0]                  wtc_addr_type;
  typedef logic [`WTC_DATA_W-1:0]                  wtc_data_type;
  typedef logic [`WTC_TAG_W-1:0]                   wtc_tag_type;
  typedef logic [`WTC_SET_W-1:0]                   wtc_set_type;
  typedef logic [`WTC_WAY_W-1:0]                   wtc_way_type;
  typedef logic [`WTC_OFF_W-1:0]                   wtc_off_type;
  typedef logic [`WTC_IDX_W-1:0]                   wtc_idx_type;
  typedef logic [`WTC_WAYS-1:0][`WTC_WAY_W-1:0]    wtc_age_row_type;
endpackage

`default_nettype wire

//--- core/wtc_tag_dir.sv
/*
  One bank of the tag directory: a tag and a valid bit per set, a lookup
  port, a snoop port that invalidates and a fill port that loads.
  Assumes all ports are synchronous to clk.
*/
`default_nettype none
`include "wtc_consts.svh"

module wtc_tag_dir import wtc_pkg::*; (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire wtc_set_type look_set,
  input  wire wtc_tag_type look_tag,
  output logic             look_hit,
  input  wire logic        snoop_en,
  input  wire wtc_set_type snoop_set,
  input  wire wtc_tag_type snoop_tag,
  input  wire logic        fill_en,
  input  wire wtc_set_type fill_set,
  input  wire wtc_tag_type fill_tag
);

  wtc_tag_type             tags      [`WTC_SETS];
  wtc_tag_type             next_tags [`WTC_SETS];
  logic [`WTC_SETS-1:0]    valid;
  logic [`WTC_SETS-1:0]    next_valid;
  logic                    snoop_hit;

  // ----------------------------------------------------------------------
  // Compare and update
  // ----------------------------------------------------------------------
  assign look_hit  = valid[look_set] && (tags[look_set] == look_tag);
  assign snoop_hit = snoop_en && valid[snoop_set] && (tags[snoop_set] == snoop_tag);

  always_comb begin
    next_tags  = tags;
    next_valid = valid;
    if (snoop_hit) begin
      next_valid[snoop_set] = 1'b0;
    end
    // Fill comes last: a snoop on the old tag of this set must not undo it
    if (fill_en) begin
      next_tags[fill_set]  = fill_tag;
      next_valid[fill_set] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      valid <= '0;
      for (int i = 0; i < `WTC_SETS; i++) begin
        tags[i] <= '0;
      end
    end else begin
      valid <= next_valid;
      tags  <= next_tags;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_snoop_invalid: assert property (@(posedge clk) disable iff (!reset_n)
    snoop_hit && !(fill_en && fill_set == snoop_set) |=> !valid[$past(snoop_set)])
    else $error("snooped line still valid");

  a_reset_clear: assert property (@(posedge clk)
    $rose(reset_n) |-> valid == '0)
    else $error("valid bits not cleared by reset");

  a_fill_tag: assert property (@(posedge clk) disable iff (!reset_n)
    fill_en |=> valid[$past(fill_set)] && tags[$past(fill_set)] == $past(fill_tag))
    else $error("fill did not load tag and valid");

endmodule // wtc_tag_dir

`default_nettype wire

//--- core/wtc_cache_ctrl.sv
/*
  Write-through cache controller: four-bank tag directory, flip-flop data
  store, line refill, posted write-through and snoop invalidation.
  Assumes processor, memory bus and snoop inputs all run on clk, and that
  the processor holds cpu_req and its fields until cpu_ready.
*/
`default_nettype none
`include "wtc_consts.svh"

module wtc_cache_ctrl import wtc_pkg::*; (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          assoc_mode,
  input  wire logic          cpu_req,
  input  wire logic          cpu_we,
  input  wire wtc_addr_type  cpu_addr,
  input  wire wtc_data_type  cpu_wdata,
  output logic               cpu_ready,
  output wtc_data_type       cpu_rdata,
  output logic               mem_req,
  output logic               mem_we,
  output wtc_addr_type       mem_addr,
  output wtc_data_type       mem_wdata,
  input  wire wtc_data_type  mem_rdata,
  input  wire logic          mem_ack,
  input  wire logic          snoop_valid,
  input  wire wtc_addr_type  snoop_addr
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic wtc_set_type set_of(wtc_addr_type a);
    return a[`WTC_SET_LSB +: `WTC_SET_W];
  endfunction

  function automatic wtc_tag_type tag_of(wtc_addr_type a);
    return a[`WTC_TAG_LSB +: `WTC_TAG_W];
  endfunction

  function automatic wtc_idx_type word_idx(wtc_way_type w, wtc_set_type s, wtc_off_type o);
    return {w, s, o};
  endfunction

  function automatic wtc_way_type lru_victim(wtc_age_row_type r);
    wtc_way_type v;
    v = '0;
    for (int i = 0; i < `WTC_WAYS; i++) begin
      if (r[i] == `WTC_AGE_OLD) v = wtc_way_type'(i);
    end
    return v;
  endfunction

  function automatic wtc_age_row_type lru_touch(wtc_age_row_type r, wtc_way_type w);
    wtc_age_row_type n;
    n = r;
    for (int i = 0; i < `WTC_WAYS; i++) begin
      if (r[i] < r[w]) n[i] = r[i] + 2'h1;
    end
    n[w] = 2'h0;
    return n;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  wtc_state_type     state,     next_state;
  logic              pend,      next_pend;
  wtc_way_type       fill_way,  next_fill_way;
  wtc_off_type       fill_word, next_fill_word;
  wtc_addr_type      miss_addr, next_miss_addr;
  logic              stale,     next_stale;
  logic              next_mem_req;
  logic              next_mem_we;
  wtc_addr_type      next_mem_addr;
  wtc_data_type      next_mem_wdata;
  wtc_data_type      data_mem [`WTC_WORDS];
  wtc_age_row_type   ages     [`WTC_SETS];

  logic [`WTC_WAYS-1:0] look_hit;
  logic [`WTC_WAYS-1:0] hit_vec;
  wtc_set_type       cpu_set;
  wtc_tag_type       cpu_tag;
  wtc_way_type       dm_way;
  wtc_way_type       hit_way;
  wtc_way_type       victim;
  logic              hit;
  logic              lookup_ok;
  logic              take_write;
  logic              read_hit;
  logic              start_fill;
  logic              fill_ack;
  logic              fill_ret;
  logic              fill_last;
  logic              snoop_line;
  logic              fill_en;
  logic              data_we;
  wtc_idx_type       data_idx;
  wtc_data_type      data_val;
  logic              age_we;
  wtc_set_type       age_set;
  wtc_way_type       age_way;

  // ----------------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------------
  assign cpu_set = set_of(cpu_addr);
  assign cpu_tag = tag_of(cpu_addr);
  assign dm_way  = cpu_tag[`WTC_WAY_W-1:0];

  for (genvar g = 0; g < `WTC_WAYS; g++) begin : g_dir
    wtc_tag_dir u_dir (
      .clk       (clk),
      .reset_n   (reset_n),
      .look_set  (cpu_set),
      .look_tag  (cpu_tag),
      .look_hit  (look_hit[g]),
      .snoop_en  (snoop_valid),
      .snoop_set (set_of(snoop_addr)),
      .snoop_tag (tag_of(snoop_addr)),
      .fill_en   (fill_en && fill_way == wtc_way_type'(g)),
      .fill_set  (set_of(miss_addr)),
      .fill_tag  (tag_of(miss_addr))
    );
  end

  // Mode is static: switching it with valid lines can leave stale copies
  always_comb begin
    hit_vec = assoc_mode ? look_hit
                         : (look_hit & (4'h1 << dm_way));
    hit     = |hit_vec;
    hit_way = '0;
    for (int i = 0; i < `WTC_WAYS; i++) begin
      if (hit_vec[i]) hit_way = wtc_way_type'(i);
    end
    victim = assoc_mode ? lru_victim(ages[cpu_set]) : dm_way;
  end

  assign lookup_ok  = (state == st_idle) && cpu_req;
  assign take_write = lookup_ok && cpu_we && !pend;
  assign read_hit   = lookup_ok && !cpu_we && hit;
  assign start_fill = lookup_ok && !cpu_we && !hit && !pend;
  assign fill_ack   = (state == st_refill) && mem_ack;
  assign fill_ret   = fill_ack && cpu_req && fill_word == miss_addr[1:0];
  assign fill_last  = fill_ack && fill_word == `WTC_LINE_LAST;
  // A snoop on the line being fetched makes the fetched copy stale
  assign snoop_line = snoop_valid &&
                      snoop_addr[`WTC_ADDR_W-1:`WTC_SET_LSB] ==
                      miss_addr[`WTC_ADDR_W-1:`WTC_SET_LSB];
  assign fill_en    = fill_last && !stale && !snoop_line;

  assign cpu_ready  = read_hit || take_write || fill_ret;
  assign cpu_rdata  = fill_ret ? mem_rdata
                               : data_mem[word_idx(hit_way, cpu_set, cpu_addr[1:0])];

  // ----------------------------------------------------------------------
  // Sequencer and memory port
  // ----------------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_pend      = pend;
    next_fill_way  = fill_way;
    next_fill_word = fill_word;
    next_miss_addr = miss_addr;
    next_stale     = stale || (state == st_refill && snoop_line);
    next_mem_req   = mem_req;
    next_mem_we    = mem_we;
    next_mem_addr  = mem_addr;
    next_mem_wdata = mem_wdata;
    case (state)
      st_idle: begin
        if (pend && mem_ack) begin
          next_pend    = 1'b0;
          next_mem_req = 1'b0;
        end
        if (take_write) begin
          next_pend      = 1'b1;
          next_mem_req   = 1'b1;
          next_mem_we    = 1'b1;
          next_mem_addr  = cpu_addr;
          next_mem_wdata = cpu_wdata;
        end else if (start_fill) begin
          next_state     = st_refill;
          next_miss_addr = cpu_addr;
          next_fill_way  = victim;
          next_fill_word = '0;
          next_stale     = 1'b0;
          next_mem_req   = 1'b1;
          next_mem_we    = 1'b0;
          next_mem_addr  = {cpu_addr[`WTC_ADDR_W-1:`WTC_SET_LSB], 2'h0};
        end
      end
      st_refill: begin
        if (fill_ack) begin
          if (fill_last) begin
            next_state   = st_idle;
            next_mem_req = 1'b0;
          end else begin
            next_fill_word = fill_word + 2'h1;
            next_mem_addr  = {mem_addr[`WTC_ADDR_W-1:`WTC_SET_LSB], fill_word + 2'h1};
          end
        end
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state     <= st_idle;
      pend      <= 1'b0;
      fill_way  <= '0;
      fill_word <= '0;
      miss_addr <= '0;
      stale     <= 1'b0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
    end else begin
      state     <= next_state;
      pend      <= next_pend;
      fill_way  <= next_fill_way;
      fill_word <= next_fill_word;
      miss_addr <= next_miss_addr;
      stale     <= next_stale;
      mem_req   <= next_mem_req;
      mem_we    <= next_mem_we;
      mem_addr  <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Data store and replacement ages
  // ----------------------------------------------------------------------
  // Write misses never touch the store or ages, so no line is displaced
  always_comb begin
    data_we  = fill_ack || (take_write && hit);
    data_idx = fill_ack ? word_idx(fill_way, set_of(miss_addr), fill_word)
                        : word_idx(hit_way, cpu_set, cpu_addr[1:0]);
    data_val = fill_ack ? mem_rdata : cpu_wdata;
    age_we   = read_hit || (take_write && hit) || fill_en;
    age_set  = fill_en ? set_of(miss_addr) : cpu_set;
    age_way  = fill_en ? fill_way : hit_way;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < `WTC_SETS; i++) begin
        ages[i] <= `WTC_AGE_RST;
      end
    end else begin
      if (data_we) data_mem[data_idx] <= data_val;
      if (age_we) ages[age_set] <= lru_touch(ages[age_set], age_way);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_write_taken;
    cpu_req && cpu_we && cpu_ready;
  endsequence

  sequence s_mem_write_out;
    mem_req && mem_we && mem_addr == $past(cpu_addr) && mem_wdata == $past(cpu_wdata);
  endsequence

  sequence s_fill_start;
    state == st_idle && cpu_req && !cpu_we && !hit && !pend;
  endsequence

  sequence s_fill_first;
    state == st_refill && mem_req && !mem_we && mem_addr[1:0] == 2'h0;
  endsequence

  a_hit_valid: assert property (
    cpu_ready && !cpu_we && state == st_idle |-> (look_hit & hit_vec) != '0)
    else $error("read answered without valid tag match");

  a_hit_no_wait: assert property (
    cpu_req && !cpu_we && state == st_idle && hit |-> cpu_ready)
    else $error("read hit was stalled");

  a_write_post: assert property (s_write_taken |=> s_mem_write_out)
    else $error("write not forwarded to memory at once");

  a_write_stall: assert property (
    cpu_req && cpu_we && pend |-> !cpu_ready)
    else $error("write accepted while earlier write pending");

  a_miss_bypass: assert property (
    s_write_taken ##0 !hit |-> !fill_en && !age_we && !data_we)
    else $error("write miss altered the cache");

  a_refill_start: assert property (s_fill_start |=> s_fill_first)
    else $error("read miss did not start a line fetch");

  a_refill_len: assert property (
    fill_ack && fill_word != `WTC_LINE_LAST |=> state == st_refill && mem_req)
    else $error("refill ended before four words");

  a_direct_one: assert property (
    !assoc_mode |-> (hit_vec & ~(4'h1 << dm_way)) == '0)
    else $error("direct-mapped hit outside its one location");

endmodule // wtc_cache_ctrl

`default_nettype wire

//--- tb/wtc_mem_model.sv
/*
  Memory bus model: acks each transfer after dly idle cycles, keeps
  written and snooped words, counts reads and writes.
  Assumes one transfer at a time, all on clk.
*/
`default_nettype none

module wtc_mem_model import wtc_pkg::*; (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [3:0]   dly,
  input  wire logic         mem_req,
  input  wire logic         mem_we,
  input  wire wtc_addr_type mem_addr,
  input  wire wtc_data_type mem_wdata,
  output var wtc_data_type  mem_rdata,
  output var logic          mem_ack,
  input  wire logic         snoop_valid,
  input  wire wtc_addr_type snoop_addr,
  input  wire wtc_data_type snoop_data,
  output var int            wr_count,
  output var int            rd_count,
  output var wtc_addr_type  wr_addr,
  output var wtc_data_type  wr_data
);
  timeunit 1ns;
  timeprecision 100ps;

  wtc_data_type store [wtc_addr_type];
  logic [3:0]   wait_cnt;

  // Unwritten words hold a pattern made from their address
  function automatic wtc_data_type peek(input wtc_addr_type a);
    return store.exists(a) ? store[a] : {~a, a};
  endfunction

  // Data toggles outside read acks so a stale word never looks valid
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (snoop_valid) begin
      store[snoop_addr] = snoop_data;
    end
    if (!reset_n) begin
      mem_rdata <= '0;
      wait_cnt <= '0;
      wr_count <= 0;
      rd_count <= 0;
    end else if (mem_req && !mem_ack) begin
      if (wait_cnt == dly) begin
        wait_cnt <= '0;
        mem_ack <= 1'b1;
        if (mem_we) begin
          store[mem_addr] = mem_wdata;
          wr_count <= wr_count + 1;
          wr_addr <= mem_addr;
          wr_data <= mem_wdata;
        end else begin
          mem_rdata <= peek(mem_addr);
          rd_count <= rd_count + 1;
        end
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule // wtc_mem_model

`default_nettype wire

//--- tb/testbench.sv
/*
  Self-checking bench for the write-through cache controller.
  Assumes wtc_pkg is compiled and the memory model sits on the bus.
*/
`default_nettype none

module testbench import wtc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic         clk, reset_n, assoc_mode, cpu_req, cpu_we, cpu_ready;
  wtc_addr_type cpu_addr, mem_addr, snoop_addr, wr_addr;
  wtc_data_type cpu_wdata, cpu_rdata, mem_wdata, mem_rdata, snoop_data, wr_data, got;
  logic         mem_req, mem_we, mem_ack, snoop_valid;
  logic [3:0]   dly;
  int           wr_count, rd_count, waits, errors, tests_run;
  wtc_data_type shadow [wtc_addr_type];

  wtc_cache_ctrl u_dut (.clk(clk), .reset_n(reset_n), .assoc_mode(assoc_mode),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .snoop_valid(snoop_valid), .snoop_addr(snoop_addr));

  wtc_mem_model u_mem (.clk(clk), .reset_n(reset_n), .dly(dly), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .snoop_valid(snoop_valid), .snoop_addr(snoop_addr),
    .snoop_data(snoop_data), .wr_count(wr_count), .rd_count(rd_count),
    .wr_addr(wr_addr), .wr_data(wr_data));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input wtc_data_type g, input wtc_data_type e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic wtc_data_type memv(input wtc_addr_type a);
    return shadow.exists(a) ? shadow[a] : {~a, a};
  endfunction

  function automatic wtc_addr_type mk(input wtc_tag_type t, input wtc_set_type s,
                                      input wtc_off_type o);
    return {t, s, o};
  endfunction

  // Request held until cpu_ready; the next edge takes it
  task automatic acc(input logic we, input wtc_addr_type a, input wtc_data_type d);
    cpu_req = 1'b1;
    cpu_we = we;
    cpu_addr = a;
    cpu_wdata = d;
    waits = 0;
    #1;
    while (cpu_ready !== 1'b1) begin
      @(negedge clk);
      #1;
      waits++;
      if (waits > 300) begin
        errors++;
        end_of_test();
      end
    end
    got = cpu_rdata;
    if (we) begin
      shadow[a] = d;
    end
    @(negedge clk);
  endtask

  task automatic idle();
    int n;
    cpu_req = 1'b0;
    @(negedge clk);
    n = 0;
    while (mem_req !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        errors++;
        end_of_test();
      end
    end
  endtask

  task automatic rdchk(input wtc_addr_type a, input logic hit);
    acc(1'b0, a, '0);
    idle();
    chk(got, memv(a));
    chk(32'(waits == 0), 32'(hit));
  endtask

  task automatic snoop(input wtc_addr_type a, input wtc_data_type d);
    snoop_valid = 1'b1;
    snoop_addr = a;
    snoop_data = d;
    shadow[a] = d;
    @(negedge clk);
    snoop_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic do_reset(input logic m);
    @(negedge clk);
    assoc_mode = m;
    reset_n = 1'b0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_refill();
    int base;
    base = rd_count;
    rdchk(mk(10'h005, 4'h3, 2'h2), 1'b0);
    chk(32'(rd_count - base), 32'h4);
    for (int i = 0; i < 4; i++) begin
      rdchk(mk(10'h005, 4'h3, 2'(i)), 1'b1);
    end
  endtask

  // Tags 008 and 00c share one slot when direct-mapped
  task automatic t_direct();
    rdchk(mk(10'h008, 4'h1, 2'h0), 1'b0);
    rdchk(mk(10'h009, 4'h1, 2'h0), 1'b0);
    rdchk(mk(10'h008, 4'h1, 2'h0), 1'b1);
    rdchk(mk(10'h00c, 4'h1, 2'h0), 1'b0);
    rdchk(mk(10'h008, 4'h1, 2'h0), 1'b0);
    rdchk(mk(10'h009, 4'h1, 2'h0), 1'b1);
  endtask

  task automatic t_write();
    int base;
    base = wr_count;
    dly = 4'h4;
    acc(1'b1, mk(10'h005, 4'h3, 2'h0), 32'h1234_5678);
    chk(32'(waits), 32'h0);
    acc(1'b1, mk(10'h005, 4'h3, 2'h1), 32'h9abc_def0);
    chk(32'(waits > 0), 32'h1);
    idle();
    chk(32'(wr_count - base), 32'h2);
    chk(32'(wr_addr), 32'(mk(10'h005, 4'h3, 2'h1)));
    chk(wr_data, 32'h9abc_def0);
    dly = 4'h0;
    rdchk(mk(10'h005, 4'h3, 2'h0), 1'b1);
    rdchk(mk(10'h005, 4'h3, 2'h1), 1'b1);
  endtask

  task automatic t_snoop();
    snoop(mk(10'h006, 4'h3, 2'h3), 32'h5555_aaaa);
    rdchk(mk(10'h005, 4'h3, 2'h3), 1'b1);
    snoop(mk(10'h005, 4'h3, 2'h3), 32'h7777_1111);
    rdchk(mk(10'h005, 4'h3, 2'h3), 1'b0);
    rdchk(mk(10'h005, 4'h3, 2'h1), 1'b1);
  endtask

  // Tag 1fd lands in the same slot as cached tag 005
  task automatic t_wmiss();
    int base;
    base = wr_count;
    acc(1'b1, mk(10'h1fd, 4'h3, 2'h0), 32'h0bad_cafe);
    chk(32'(waits), 32'h0);
    idle();
    chk(32'(wr_count - base), 32'h1);
    rdchk(mk(10'h005, 4'h3, 2'h0), 1'b1);
    rdchk(mk(10'h1fd, 4'h3, 2'h0), 1'b0);
  endtask

  task automatic t_assoc();
    wtc_tag_type t [5];
    t = '{10'h010, 10'h014, 10'h018, 10'h01c, 10'h020};
    rdchk(mk(10'h1fd, 4'h3, 2'h0), 1'b0);
    for (int i = 0; i < 4; i++) begin
      rdchk(mk(t[i], 4'h5, 2'h1), 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      rdchk(mk(t[i], 4'h5, 2'h1), 1'b1);
    end
    rdchk(mk(t[4], 4'h5, 2'h1), 1'b0);
    for (int i = 1; i < 4; i++) begin
      rdchk(mk(t[i], 4'h5, 2'h1), 1'b1);
    end
    rdchk(mk(t[0], 4'h5, 2'h1), 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    reset_n = 1'b0;
    assoc_mode = 1'b0;
    cpu_req = 1'b0;
    cpu_we = 1'b0;
    cpu_addr = '0;
    cpu_wdata = '0;
    snoop_valid = 1'b0;
    snoop_addr = '0;
    snoop_data = '0;
    dly = 4'h0;
    errors = 0;
    tests_run = 0;
    do_reset(1'b0);
    t_refill();
    t_direct();
    t_write();
    t_snoop();
    t_wmiss();
    do_reset(1'b1);
    t_assoc();
    end_of_test();
  end
endmodule // testbench

`default_nettype wire
